// *** logic/acs_clk_select.v ***
// Conversion clock source selection: detects an external clock on the frequency pin.
// Assumes freq_sel_in is sampled synchronously to clk_in, which runs much faster.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"

module acs_clk_select #(
    parameter TIMEOUT_CYC = (`ACS_EXT_TIMEOUT_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire freq_sel_in,
    output reg ext_sel_q,
    output reg ext_tick_q,
    output reg src_change_q
);

    reg pin_prev_q;
    reg seen_edge_q;
    reg [15:0] gap_cnt_q;
    wire pin_rise;
    wire timed_out;

    assign pin_rise = freq_sel_in & ~pin_prev_q;
    assign timed_out = (gap_cnt_q >= TIMEOUT_CYC[15:0]);

    // ==========================================================
    // Edge detection and presence decision
    // Two edges within the timeout are needed before switching, so a single
    // strap change on the pin never counts as a clock.
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_prev_q <= 1'b0;
            seen_edge_q <= 1'b0;
            gap_cnt_q <= 16'h0000;
            ext_sel_q <= 1'b0;
            ext_tick_q <= 1'b0;
            src_change_q <= 1'b0;
        end else begin
            pin_prev_q <= freq_sel_in;
            src_change_q <= 1'b0;
            // Ticks pass only whole and only from the selected source
            ext_tick_q <= pin_rise & ext_sel_q;
            if (pin_rise) begin
                gap_cnt_q <= 16'h0000;
                seen_edge_q <= 1'b1;
                if (seen_edge_q && !ext_sel_q) begin
                    ext_sel_q <= 1'b1;
                    src_change_q <= 1'b1;
                end
            end else if (timed_out) begin
                seen_edge_q <= 1'b0;
                if (ext_sel_q) begin
                    ext_sel_q <= 1'b0;
                    src_change_q <= 1'b1;
                end
            end else begin
                gap_cnt_q <= gap_cnt_q + 16'h0001;
            end
        end
    end

endmodule // acs_clk_select

`default_nettype wire

// *** logic/acs_sequencer.v ***
// Conversion sequencer: power-on reset, conversion timing, sleep and serial data output.
// Assumes all inputs are synchronous to clk_in; the modulator result arrives on result_in.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"

module acs_sequencer #(
    parameter POR_CYC = (`ACS_POR_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
    parameter CONV60_1X_CYC = (`ACS_CONV60_1X_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
    parameter CONV50_1X_CYC = (`ACS_CONV50_1X_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
    parameter CONV5060_1X_CYC = (`ACS_CONV5060_1X_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
    parameter CONV60_2X_CYC = (`ACS_CONV60_2X_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
    parameter CONV50_2X_CYC = (`ACS_CONV50_2X_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
    parameter CONV5060_2X_CYC = (`ACS_CONV5060_2X_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
    parameter EXT_TIMEOUT_CYC = (`ACS_EXT_TIMEOUT_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire supply_low_in,
    input wire freq_sel_in,
    input wire cfg_wr_in,
    input wire [1:0] cfg_rej_in,
    input wire cfg_speed_2x_in,
    input wire [2:0] cfg_gain_in,
    input wire cfg_im_in,
    input wire result_sign_in,
    input wire [16:0] result_in,
    input wire cs_n_in,
    input wire sck_in,
    output reg [1:0] state_out,
    output reg int_osc_en_out,
    output reg ext_clk_active_out,
    output reg cal_offset_out,
    output reg conv_done_out,
    output reg result_suspect_out,
    output reg filt_frame_out,
    output reg sdo_out,
    output reg sdo_oe_out,
    output reg sck_out,
    output reg sck_oe_out
);

    // Half period of the generated serial clock on the internal oscillator
    localparam INT_SCK_HALF_CYC = (`ACS_OUT_LIMIT_NS / `ACS_INT_SCK_HALVES) / `ACS_CLK_NS;

    reg [1:0] state_q;
    reg [21:0] por_cnt_q;
    reg [1:0] rej_q;
    reg speed_2x_q;
    reg [1:0] conv_rej_q;
    reg conv_2x_q;
    reg conv_ext_q;
    reg [23:0] conv_cnt_q;
    reg [23:0] conv_len;
    reg [12:0] frame_cnt_q;
    reg suspect_q;
    reg [23:0] word_q;
    reg [4:0] bits_left_q;
    reg ext_sck_mode_q;
    reg cs_prev_q;
    reg sck_prev_q;
    reg [9:0] half_cnt_q;
    reg int_sck_q;
    reg out_done;
    reg shift_now;
    wire ext_sel;
    wire ext_tick;
    wire src_change;
    wire cs_fall;
    wire cs_rise;
    wire sck_fall;
    wire half_due;
    wire conv_step;
    wire conv_end;

    // ==========================================================
    // Conversion clock source
    acs_clk_select #(
        .TIMEOUT_CYC(EXT_TIMEOUT_CYC)
    ) u_clk_select (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in | supply_low_in),
        .freq_sel_in(freq_sel_in),
        .ext_sel_q(ext_sel),
        .ext_tick_q(ext_tick),
        .src_change_q(src_change)
    );

    // Pin edges; inputs are already synchronous so no synchroniser stage
    assign cs_fall = ~cs_n_in & cs_prev_q;
    assign cs_rise = cs_n_in & ~cs_prev_q;
    assign sck_fall = ~sck_in & sck_prev_q;

    // Internal oscillator counts every cycle, external mode counts its ticks
    assign conv_step = conv_ext_q ? ext_tick : 1'b1;
    assign conv_end = conv_step && (conv_cnt_q + 24'h000001 >= conv_len);

    // Half-period of the generated serial clock comes from whichever source is live
    assign half_due = ext_sel ? (ext_tick && (half_cnt_q[2:0] + 3'h1 >= `ACS_EXT_SCK_HALF_TICKS))
                              : (half_cnt_q + 10'h001 >= INT_SCK_HALF_CYC[9:0]);

    // ==========================================================
    // Conversion length by source and speed, and by rejection mode on the internal oscillator
    always @* begin
        conv_len = CONV5060_1X_CYC[23:0];
        if (conv_ext_q) begin
            conv_len = conv_2x_q ? `ACS_EXT_CONV_2X : `ACS_EXT_CONV_1X;
        end else if (conv_2x_q) begin
            case (conv_rej_q)
                `ACS_REJ_60: conv_len = CONV60_2X_CYC[23:0];
                `ACS_REJ_50: conv_len = CONV50_2X_CYC[23:0];
                default: conv_len = CONV5060_2X_CYC[23:0];
            endcase
        end else begin
            case (conv_rej_q)
                `ACS_REJ_60: conv_len = CONV60_1X_CYC[23:0];
                `ACS_REJ_50: conv_len = CONV50_1X_CYC[23:0];
                default: conv_len = CONV5060_1X_CYC[23:0];
            endcase
        end
    end

    // ==========================================================
    // Serial shift decision for the current cycle
    // Internal mode shifts on the falling half of the generated clock;
    // external mode shifts on the host's falling edge.
    always @* begin
        shift_now = 1'b0;
        if (state_q == `ACS_ST_OUT && !cs_n_in) begin
            if (ext_sck_mode_q) begin
                shift_now = sck_fall;
            end else begin
                shift_now = half_due && int_sck_q;
            end
        end
        out_done = shift_now && (bits_left_q == 5'h01);
    end

    // ==========================================================
    // Main sequencer
    // Supply-low and system reset both clear everything; the power-on count
    // then runs before the first conversion.
    always @(posedge clk_in) begin
        if (sys_rst_in || supply_low_in) begin
            state_q <= `ACS_ST_POR;
            por_cnt_q <= 22'h000000;
            rej_q <= `ACS_REJ_DEFAULT;
            speed_2x_q <= 1'b0;
            conv_rej_q <= `ACS_REJ_DEFAULT;
            conv_2x_q <= 1'b0;
            conv_ext_q <= 1'b0;
            conv_cnt_q <= 24'h000000;
            frame_cnt_q <= 13'h0000;
            suspect_q <= 1'b0;
            word_q <= 24'hFFFFFF;
            bits_left_q <= 5'h00;
            ext_sck_mode_q <= 1'b1;
            cs_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
            half_cnt_q <= 10'h000;
            int_sck_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_n_in;
            sck_prev_q <= sck_in;
            // Configuration is held here and only taken at a conversion start
            if (cfg_wr_in) begin
                rej_q <= cfg_rej_in;
                speed_2x_q <= cfg_speed_2x_in;
            end
            // Serial clock mode is picked on every chip select falling edge
            if (cs_fall) begin
                ext_sck_mode_q <= ~sck_in;
            end
            case (state_q)
                `ACS_ST_POR: begin
                    if (por_cnt_q + 22'h000001 >= POR_CYC[21:0]) begin
                        state_q <= `ACS_ST_CONV;
                        conv_rej_q <= cfg_wr_in ? cfg_rej_in : rej_q;
                        conv_2x_q <= cfg_wr_in ? cfg_speed_2x_in : speed_2x_q;
                        conv_ext_q <= ext_sel;
                        conv_cnt_q <= 24'h000000;
                        frame_cnt_q <= 13'h0000;
                        suspect_q <= 1'b0;
                    end else begin
                        por_cnt_q <= por_cnt_q + 22'h000001;
                    end
                end
                `ACS_ST_CONV: begin
                    if (src_change) begin
                        // Retime in the new source's units; only this result is flagged
                        suspect_q <= 1'b1;
                        conv_ext_q <= ext_sel;
                        conv_cnt_q <= 24'h000000;
                    end else if (conv_end) begin
                        // Result goes straight into the output word, EOC low
                        word_q <= {1'b0, 1'b0, result_sign_in, result_in, cfg_gain_in, cfg_im_in};
                        bits_left_q <= `ACS_WORD_BITS;
                        state_q <= `ACS_ST_SLEEP;
                    end else if (conv_step) begin
                        conv_cnt_q <= conv_cnt_q + 24'h000001;
                    end
                    // Filter frame boundaries in external clock mode
                    if (conv_ext_q && ext_tick) begin
                        if (frame_cnt_q + 13'h0001 >= `ACS_EXT_FILT_DIV) begin
                            frame_cnt_q <= 13'h0000;
                        end else begin
                            frame_cnt_q <= frame_cnt_q + 13'h0001;
                        end
                    end
                end
                `ACS_ST_SLEEP: begin
                    // Source changes here need no action
                    if (!cs_n_in) begin
                        state_q <= `ACS_ST_OUT;
                        half_cnt_q <= 10'h000;
                        int_sck_q <= 1'b1;
                    end
                end
                default: begin
                    if (cs_n_in) begin
                        // Early chip select release drops the rest of the word
                        state_q <= `ACS_ST_CONV;
                        conv_rej_q <= rej_q;
                        conv_2x_q <= speed_2x_q;
                        conv_ext_q <= ext_sel;
                        conv_cnt_q <= 24'h000000;
                        frame_cnt_q <= 13'h0000;
                        suspect_q <= 1'b0;
                        word_q <= 24'hFFFFFF;
                        bits_left_q <= 5'h00;
                    end else begin
                        if (!ext_sck_mode_q) begin
                            // Counter restarts per half; a source swap only stretches one half
                            if (half_due) begin
                                half_cnt_q <= 10'h000;
                                int_sck_q <= ~int_sck_q;
                            end else if (!ext_sel || ext_tick) begin
                                half_cnt_q <= half_cnt_q + 10'h001;
                            end
                        end
                        if (out_done) begin
                            // Word complete: next conversion begins, line goes high
                            state_q <= `ACS_ST_CONV;
                            conv_rej_q <= rej_q;
                            conv_2x_q <= speed_2x_q;
                            conv_ext_q <= ext_sel;
                            conv_cnt_q <= 24'h000000;
                            frame_cnt_q <= 13'h0000;
                            suspect_q <= 1'b0;
                            word_q <= 24'hFFFFFF;
                            bits_left_q <= 5'h00;
                        end else if (shift_now) begin
                            word_q <= {word_q[22:0], 1'b1};
                            bits_left_q <= bits_left_q - 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Registered outputs
    // Calibration sits inside the conversion window, so the host sees the
    // same convert, sleep and output sequence either way.
    always @(posedge clk_in) begin
        if (sys_rst_in || supply_low_in) begin
            state_out <= `ACS_ST_POR;
            int_osc_en_out <= 1'b1;
            ext_clk_active_out <= 1'b0;
            cal_offset_out <= 1'b0;
            conv_done_out <= 1'b0;
            result_suspect_out <= 1'b0;
            filt_frame_out <= 1'b0;
            sdo_out <= 1'b1;
            sdo_oe_out <= 1'b0;
            sck_out <= 1'b1;
            sck_oe_out <= 1'b0;
        end else begin
            state_out <= state_q;
            int_osc_en_out <= ~ext_sel;
            ext_clk_active_out <= ext_sel;
            // First half of a 1x cycle is the offset pass; 2x skips it
            cal_offset_out <= (state_q == `ACS_ST_CONV) && !conv_2x_q
                              && (conv_cnt_q < {1'b0, conv_len[23:1]});
            conv_done_out <= (state_q == `ACS_ST_CONV) && !src_change && conv_end;
            if (state_q == `ACS_ST_CONV && !src_change && conv_end) begin
                result_suspect_out <= suspect_q;
            end
            filt_frame_out <= (state_q == `ACS_ST_CONV) && conv_ext_q && ext_tick
                              && (frame_cnt_q + 13'h0001 >= `ACS_EXT_FILT_DIV);
            // Line is high through conversion (EOC), then shows the word
            if (state_q == `ACS_ST_CONV || state_q == `ACS_ST_POR) begin
                sdo_out <= 1'b1;
            end else begin
                sdo_out <= word_q[23];
            end
            sdo_oe_out <= ~cs_n_in;
            sck_out <= (state_q == `ACS_ST_OUT && !ext_sck_mode_q) ? int_sck_q : 1'b1;
            sck_oe_out <= (state_q == `ACS_ST_OUT) && !ext_sck_mode_q && !cs_n_in;
        end
    end

endmodule // acs_sequencer

`default_nettype wire

// *** shared/acs_defs.vh ***
// Constants for the conversion sequencer: state codes, mode codes, times and counts.
// Assumes a 40 MHz system clock; times are in nanoseconds, counts derive from them.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ==========================================================
// Clock
`define ACS_CLK_NS 25

// ==========================================================
// Sequencer states
`define ACS_ST_POR 2'h0
`define ACS_ST_CONV 2'h1
`define ACS_ST_SLEEP 2'h2
`define ACS_ST_OUT 2'h3

// ==========================================================
// Line rejection modes
`define ACS_REJ_5060 2'h0
`define ACS_REJ_60 2'h1
`define ACS_REJ_50 2'h2
`define ACS_REJ_DEFAULT 2'h0

// ==========================================================
// Conversion times on the internal oscillator
`define ACS_CONV60_1X_NS 133000000
`define ACS_CONV50_1X_NS 160000000
`define ACS_CONV5060_1X_NS 147000000
`define ACS_CONV60_2X_NS 67000000
`define ACS_CONV50_2X_NS 80000000
`define ACS_CONV5060_2X_NS 73600000

// Conversion length in external clock periods
`define ACS_EXT_CONV_1X 24'hA04C
`define ACS_EXT_CONV_2X 24'h504C
// External clock periods per filter rejection frame
`define ACS_EXT_FILT_DIV 13'h1400

// ==========================================================
// Data output
`define ACS_WORD_BITS 5'h18
`define ACS_OUT_LIMIT_NS 620000
`define ACS_INT_SCK_HALVES 48
`define ACS_EXT_SCK_HALF_TICKS 3'h4

// ==========================================================
// Power-on reset and clock detection
`define ACS_POR_NS 4000000
`define ACS_EXT_MIN_PERIOD_NS 100000
`define ACS_EXT_TIMEOUT_NS 200000

`endif

// *** sim/acs_host_model.sv ***
// Host model: selects the converter and clocks the word out with its own serial clock, or leaves the clocking to the converter when falls_in is zero.
// Assumes go_in is a one-cycle pulse given while busy_out is low.
`timescale 1ns/1ps
`default_nettype none
module acs_host_model #(
    parameter HALF = 4
) (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [4:0] falls_in,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic busy_out,
    output logic [23:0] word_out
);
    // ====
    // Transfer: clock low at select keeps external mode; bits taken on rises
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        busy_out = 1'b0;
        word_out = 24'h0;
        forever begin
            @(posedge clk_in);
            if (go_in) begin
                busy_out <= 1'b1;
                cs_n_out <= 1'b0;
                sck_out <= falls_in == 5'h00;
                repeat (falls_in ? HALF : 24300) @(posedge clk_in);
                for (int i = 0; i < falls_in; i++) begin
                    sck_out <= 1'b1;
                    // An undriven line reads inverted, so a float never passes
                    word_out[23 - i] <= sdo_oe_in ? sdo_in : ~sdo_in;
                    repeat (HALF) @(posedge clk_in);
                    sck_out <= 1'b0;
                    repeat (HALF) @(posedge clk_in);
                end
                cs_n_out <= 1'b1;
                busy_out <= 1'b0;
                sck_out <= 1'b0;
            end
        end
    end
endmodule // acs_host_model
`default_nettype wire

// *** sim/acs_sequencer_bench.sv ***
// Testbench for the conversion sequencer with short counts and a host model.
// Assumes the sequencer and host model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_bench;
    localparam int POR = 20, C60 = 300, C50 = 360, C56 = 330, D60 = 150, D50 = 180, D56 = 166;
    localparam int EXT = 41112, LIMIT = 80000;
    logic clk_in, sys_rst_in, supply_low_in, freq_sel_in, cfg_wr_in, cfg_speed_2x_in, cfg_im_in;
    logic result_sign_in, ext_on, host_go, cal_seen;
    logic [1:0] cfg_rej_in;
    logic [2:0] cfg_gain_in;
    logic [16:0] result_in;
    logic [4:0] host_falls;
    logic [23:0] exp_w;
    wire [23:0] host_word;
    wire [1:0] state_out;
    wire int_osc, ext_act, cal_off, done, suspect, frame, sdo, sdo_oe, sck_oe, dsck, cs_n, sck, host_busy;
    int run_len, frames, cyc, err_total, checks, isck;
    acs_sequencer #(.POR_CYC(POR), .CONV60_1X_CYC(C60), .CONV50_1X_CYC(C50), .CONV5060_1X_CYC(C56),
        .CONV60_2X_CYC(D60), .CONV50_2X_CYC(D50), .CONV5060_2X_CYC(D56), .EXT_TIMEOUT_CYC(50)) acs_sequencer_i (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .supply_low_in(supply_low_in), .freq_sel_in(freq_sel_in),
        .cfg_wr_in(cfg_wr_in), .cfg_rej_in(cfg_rej_in), .cfg_speed_2x_in(cfg_speed_2x_in),
        .cfg_gain_in(cfg_gain_in), .cfg_im_in(cfg_im_in), .result_sign_in(result_sign_in), .result_in(result_in),
        .cs_n_in(cs_n), .sck_in(sck), .state_out(state_out), .int_osc_en_out(int_osc), .ext_clk_active_out(ext_act),
        .cal_offset_out(cal_off), .conv_done_out(done), .result_suspect_out(suspect), .filt_frame_out(frame),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sck_out(dsck), .sck_oe_out(sck_oe));
    acs_host_model acs_host_model_i (.clk_in(clk_in), .go_in(host_go), .falls_in(host_falls), .sdo_in(sdo),
        .sdo_oe_in(sdo_oe), .cs_n_out(cs_n), .sck_out(sck), .busy_out(host_busy), .word_out(host_word));
    // ====
    // Clock and time-zero values
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Conversion length, offset pass and frame pulses, plus the hang guard and external clock
    always @(posedge clk_in) begin
        if (state_out === 2'h1) run_len <= run_len + 1;
        else if (state_out !== 2'h2) run_len <= 0;
        if (state_out === 2'h3 || state_out === 2'h0) cal_seen <= 1'b0;
        else if (cal_off === 1'b1) cal_seen <= 1'b1;
        if (state_out === 2'h3 || state_out === 2'h0) frames <= 0;
        else if (frame === 1'b1) frames <= frames + 1;
        if (sck_oe === 1'b1 && dsck === 1'b1) isck <= isck + 1;
        if (ext_on) freq_sel_in <= ~freq_sel_in;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            end_of_test();
        end
    end
    // ====
    // Shared tasks
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic len_ok(input int exp);
        check(run_len >= exp - 3 && run_len <= exp + 3, "conversion length");
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 50000) begin
            @(posedge clk_in);
            n++;
        end
        check(n < 50000, "no conversion end");
        @(posedge clk_in);
    endtask
    task automatic read_word(input logic [4:0] n);
        host_go <= 1'b1;
        host_falls <= n;
        @(posedge clk_in);
        host_go <= 1'b0;
        @(posedge clk_in);
        while (host_busy === 1'b1) @(posedge clk_in);
        if (n == 5'h18) check(host_word === exp_w && sck_oe === 1'b0, "output word");
    endtask
    task automatic set_cfg(input logic [1:0] rej, input logic spd);
        cfg_wr_in <= 1'b1;
        cfg_rej_in <= rej;
        cfg_speed_2x_in <= spd;
        @(posedge clk_in);
        cfg_wr_in <= 1'b0;
    endtask
    task automatic new_result(input logic [2:0] g);
        exp_w = {2'b00, ~result_sign_in, result_in + 17'h0F0F1, g, g[0]};
        result_in <= result_in + 17'h0F0F1;
        result_sign_in <= ~result_sign_in;
        cfg_gain_in <= g;
        cfg_im_in <= g[0];
    endtask
    // ====
    // Scenarios
    task automatic t_power_up();
        int n;
        n = 0;
        while (state_out !== 2'h1 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        check(n >= POR - 1 && n <= POR + 3, "power-on length");
        wait_done();
        len_ok(C56);
        check(cal_seen === 1'b1 && int_osc === 1'b1, "offset pass or source");
    endtask
    task automatic t_modes();
        logic [1:0] rej [6] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
        int len [6] = '{C60, C50, C56, D60, D50, D56};
        for (int k = 0; k < 6; k++) begin
            repeat (50) @(posedge clk_in);
            check(state_out === 2'h2 && sdo_oe === 1'b0, "left sleep");
            set_cfg(rej[k], k > 2);
            read_word(5'h18);
            check(sdo === 1'b1 && state_out === 2'h1, "no new conversion");
            new_result(k[2:0]);
            wait_done();
            len_ok(len[k]);
            check(cal_seen === (k < 3) && suspect === 1'b0, "offset pass");
        end
    endtask
    task automatic t_abort();
        read_word(5'h05);
        repeat (2) @(posedge clk_in);
        check(state_out === 2'h1, "abort kept output");
        new_result(3'h6);
        wait_done();
        len_ok(D56);
        read_word(5'h18);
    endtask
    task automatic t_supply();
        supply_low_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check(state_out === 2'h0 && int_osc === 1'b1 && sdo === 1'b1, "supply low state");
        supply_low_in <= 1'b0;
        wait_done();
        len_ok(C56);
    endtask
    task automatic t_ext();
        ext_on <= 1'b1;
        repeat (60) @(posedge clk_in);
        check(ext_act === 1'b1 && int_osc === 1'b0 && state_out === 2'h2, "clock not taken");
        set_cfg(2'h0, 1'b1);
        read_word(5'h18);
        wait_done();
        check(run_len >= EXT - 8 && run_len <= EXT + 8, "external length");
        check(frames === 4 && suspect === 1'b0, "frame count");
        read_word(5'h18);
        repeat (100) @(posedge clk_in);
        ext_on <= 1'b0;
        repeat (60) @(posedge clk_in);
        check(int_osc === 1'b1 && ext_act === 1'b0, "oscillator not back");
        wait_done();
        check(suspect === 1'b1, "source change unflagged");
        read_word(5'h18);
        wait_done();
        check(suspect === 1'b0, "later result flagged");
        len_ok(D56);
        read_word(5'h00);
        check(state_out === 2'h1 && isck > 12000 && isck <= 12400, "internal clock");
    endtask
    // ====
    // Main sequence
    initial begin
        {supply_low_in, freq_sel_in, cfg_wr_in, cfg_speed_2x_in, ext_on, host_go} = 6'h00;
        {sys_rst_in, cfg_im_in, result_sign_in} = 3'h7;
        {cfg_rej_in, cfg_gain_in, host_falls} = 10'h0A0;
        result_in = 17'h1A5C3;
        exp_w = {3'b001, 17'h1A5C3, 4'hB};
        {run_len, frames, cyc, err_total, checks, isck} = 0;
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_power_up();
        t_modes();
        t_abort();
        t_supply();
        t_ext();
        end_of_test();
    end
endmodule // acs_sequencer_bench
`default_nettype wire

// *** sim/acs_sequencer_sva.sv ***
// Checker for the conversion sequencer, watching its top-level ports only.
// Assumes one clock, clk_in; either reset input puts the block back to power-on.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_sva #(
    parameter POR_CYC = 20
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire supply_low_in,
    input wire cs_n_in,
    input wire [1:0] state_out,
    input wire int_osc_en_out,
    input wire ext_clk_active_out,
    input wire cal_offset_out,
    input wire conv_done_out,
    input wire filt_frame_out,
    input wire sdo_out,
    input wire sdo_oe_out
);
    // ====
    // Power-on length counter; the reported state lags a cycle, so allow slack
    wire rst_any = sys_rst_in | supply_low_in;
    int por_cnt_q;
    always @(posedge clk_in) begin
        if (rst_any) por_cnt_q <= 0;
        else if (state_out == 2'h0) por_cnt_q <= por_cnt_q + 1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_any);
    // ====
    // Named steps
    sequence s_leave_por;
        state_out == 2'h0 ##1 state_out != 2'h0;
    endsequence
    sequence s_cs_rise_out;
        state_out == 2'h3 && cs_n_in;
    endsequence
    // ====
    // Properties
    a_rst_outputs: assert property (disable iff (1'b0) rst_any |=> state_out == 2'h0 && int_osc_en_out
        && sdo_out && !sdo_oe_out) else $error("reset outputs wrong");
    a_por_length: assert property (s_leave_por |-> por_cnt_q >= POR_CYC - 2 && por_cnt_q <= POR_CYC + 2)
        else $error("power-on length wrong");
    a_por_to_conv: assert property (s_leave_por |-> state_out == 2'h1) else $error("no conversion after power-on");
    a_done_sleep: assert property (conv_done_out |=> state_out == 2'h2) else $error("end not into sleep");
    a_sleep_hold: assert property (state_out == 2'h2 && cs_n_in && $past(cs_n_in) && $past(cs_n_in, 2)
        |=> state_out == 2'h2) else $error("left sleep with select high");
    a_abort_conv: assert property (s_cs_rise_out |-> ##[1:3] state_out == 2'h1) else $error("abort failed");
    a_done_no_cal: assert property (conv_done_out |-> !cal_offset_out) else $error("offset pass at end");
    a_osc_exclusive: assert property (int_osc_en_out != ext_clk_active_out) else $error("clock source clash");
    a_frame_ext: assert property (filt_frame_out |-> ext_clk_active_out && state_out == 2'h1)
        else $error("frame pulse out of place");
    a_conv_sdo_high: assert property (state_out == 2'h1 && sdo_oe_out |-> sdo_out) else $error("busy line low");
    a_oe_follows: assert property ($past(!rst_any) |-> sdo_oe_out == !$past(cs_n_in))
        else $error("output enable off select");
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva #(.POR_CYC(POR_CYC)) acs_sequencer_sva_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .supply_low_in(supply_low_in), .cs_n_in(cs_n_in),
    .state_out(state_out), .int_osc_en_out(int_osc_en_out), .ext_clk_active_out(ext_clk_active_out),
    .cal_offset_out(cal_offset_out), .conv_done_out(conv_done_out), .filt_frame_out(filt_frame_out),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out));
`default_nettype wire
